// ==== design/typea_pkg.sv ====
package typea_pkg;

    // ------------------------------------------------------------
    // register map (word indices, byte address is four times)
    // ------------------------------------------------------------
    localparam logic [7:0] bit_rate_def_idx = 8'h04;
    localparam logic [7:0] typea_frame_settings_idx = 8'h05;
    localparam logic [7:0] mode_ctrl_idx = 8'h06;
    localparam logic [7:0] status_idx = 8'h07;
    localparam logic [7:0] fifo_data_idx = 8'h08;
    localparam logic [7:0] word_bytes = 8'h04;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int tx_par_off_bit = 7;
    localparam int raw_rx_bit = 6;
    localparam int transport_frame_bit = 5;
    localparam int pulse_lsb = 1;
    localparam int anticoll_bit = 0;
    localparam int tx_rate_lsb = 4;
    localparam int rx_rate_lsb = 0;
    localparam logic [7:0] settings_reset = 8'h00;
    localparam logic [7:0] bit_rate_reset = 8'h00;
    localparam logic [7:0] mode_reset = 8'h00;
    localparam logic [7:0] frame_start_byte = 8'hF0;

    // ------------------------------------------------------------
    // pulse widths in carrier periods for code 0
    // ------------------------------------------------------------
    localparam logic [5:0] pulse_base_128 = 6'h23;
    localparam logic [5:0] pulse_base_64 = 6'h12;
    localparam logic [5:0] pulse_base_32 = 6'h09;
    localparam logic [5:0] pulse_base_16 = 6'h05;
    localparam int fifo_depth = 8;

    typedef enum logic [3:0] {
        rate_106 = 4'h0,
        rate_212 = 4'h1,
        rate_424 = 4'h2,
        rate_848 = 4'h3
    } bit_rate_code_t;

    typedef struct packed {
        logic tx_par_off;
        logic raw_rx;
        logic transport_frame_enable;
        logic [3:0] pulse_width_sel;
        logic anticoll;
    } frame_cfg_t;

    typedef struct packed {
        logic tx_enable;
        logic rx_enable;
        logic [5:0] pulse_len;
        logic pulse_ok;
    } frame_status_t;

endpackage : typea_pkg

// ==== design/typea_framing_bitrate_config.sv ====
// Behaviour
// - rate codes 0..3 select fc/128, fc/64, fc/32, fc/16; others unused.
// - an out-of-range pulse code disables both transmit and receive.
// - tx parity off sends fifo data with no parity bits.
// - raw receive stores bits with parity in the fifo, no checking.
// - transport frame adds F0 and length on tx, drops F0 on rx only as the first byte after frame start.
// - the 4-bit pulse field sets modulation width in carrier periods.
// - at fc/128 code 0 gives 35, signed steps from 27 to 42.
// - code 0 gives 18, 9, 5 at fc/64, fc/32, fc/16, one per step.
// - anticollision bit selects standard or bit-oriented rx frames.
// - parity-off and raw options act only in reader modes.
// - tx rate is bits 5:4 and rx rate bits 1:0 of the rate register.
`timescale 1ns/100ps
module typea_fifo #(
    parameter int width = 9,
    parameter int depth = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [width-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [width-1:0] out_data
);
    localparam int aw = $clog2(depth);
    logic [width-1:0] mem [depth];
    logic [aw-1:0] wr_ptr;
    logic [aw-1:0] rd_ptr;
    logic [aw:0] count;
    logic push;
    logic pop;

    assign in_ready = count != (aw+1)'(depth);
    assign out_valid = count != '0;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    always_ff @(posedge hclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == aw'(depth - 1)) ? '0 : aw'(wr_ptr + 1'b1);
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == aw'(depth - 1)) ? '0 : aw'(rd_ptr + 1'b1);
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule : typea_fifo

module typea_framing_bitrate_config #(
    parameter int fifo_width = 9,
    parameter int fifo_depth = typea_pkg::fifo_depth
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic reader_mode,
    input wire logic rx_byte_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_parity,
    input wire logic rx_frame_start,
    input wire logic tx_frame_start,
    input wire logic [7:0] tx_frame_len,
    output logic tx_prefix_valid,
    output logic [7:0] tx_prefix_byte,
    input wire logic tx_prefix_ready,
    output logic tx_enable,
    output logic rx_enable,
    output logic [1:0] tx_speed_sel,
    output logic [1:0] rx_speed_sel,
    output logic tx_parity_gen,
    output logic rx_check_enable,
    output logic anticoll_rx,
    output logic [5:0] pulse_len
);
    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic rate_ok(input logic [1:0] code);
        // two-bit field can only hold codes 0..3, all supported
        rate_ok = code <= 2'(typea_pkg::rate_848);
    endfunction : rate_ok

    function automatic logic [6:0] pulse_dec(input logic [1:0] rate,
                                             input logic [3:0] code);
        logic signed [4:0] s;
        logic signed [4:0] lo;
        logic signed [4:0] hi;
        logic [5:0] base;
        s = {code[3], code};
        case (rate)
            2'h0: begin
                base = typea_pkg::pulse_base_128;
                lo = -5'sd8;
                hi = 5'sd7;
            end
            2'h1: begin
                base = typea_pkg::pulse_base_64;
                lo = -5'sd6;
                hi = 5'sd6;
            end
            2'h2: begin
                base = typea_pkg::pulse_base_32;
                lo = -5'sd4;
                hi = 5'sd4;
            end
            default: begin
                base = typea_pkg::pulse_base_16;
                lo = -5'sd3;
                hi = 5'sd3;
            end
        endcase
        // width = base + signed step, out of range flagged
        pulse_dec[5:0] = 6'(base + {{1{s[4]}}, s});
        pulse_dec[6] = (s >= lo) && (s <= hi);
    endfunction : pulse_dec

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] settings;
    logic [7:0] bit_rate_def;
    logic [7:0] mode_ctrl;
    typea_pkg::frame_cfg_t cfg;
    typea_pkg::frame_status_t stat;
    logic [6:0] pdec;
    logic rates_ok;

    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;
    logic dp_write;
    logic dp_read;
    logic [7:0] dp_addr;

    assign cfg = settings[7:0];
    assign tx_speed_sel = bit_rate_def[typea_pkg::tx_rate_lsb +: 2];
    assign rx_speed_sel = bit_rate_def[typea_pkg::rx_rate_lsb +: 2];
    assign pdec = pulse_dec(tx_speed_sel, cfg.pulse_width_sel);
    assign rates_ok = rate_ok(tx_speed_sel) && rate_ok(rx_speed_sel);

    // ------------------------------------------------------------
    // ahb-lite slave, zero wait states
    // ------------------------------------------------------------
    assign ap_valid = hsel && hready && htrans[1];
    assign ap_write = hwrite;
    assign ap_addr = haddr[7:0];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_read <= 1'b0;
            dp_addr <= 8'h00;
        end else begin
            dp_write <= ap_valid && ap_write;
            dp_read <= ap_valid && !ap_write;
            dp_addr <= ap_addr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            settings <= typea_pkg::settings_reset;
            bit_rate_def <= typea_pkg::bit_rate_reset;
            mode_ctrl <= typea_pkg::mode_reset;
        end else if (dp_write) begin
            case (dp_addr)
                typea_pkg::bit_rate_def_idx * typea_pkg::word_bytes: begin
                    bit_rate_def <= hwdata[7:0] & 8'h33;
                end
                typea_pkg::typea_frame_settings_idx * typea_pkg::word_bytes:
                begin
                    settings <= hwdata[7:0];
                end
                typea_pkg::mode_ctrl_idx * typea_pkg::word_bytes: begin
                    mode_ctrl <= hwdata[7:0] & 8'h01;
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // derived controls
    // ------------------------------------------------------------
    assign stat.tx_enable = rates_ok && pdec[6];
    assign stat.rx_enable = rates_ok && pdec[6];
    assign stat.pulse_len = pdec[5:0];
    assign stat.pulse_ok = pdec[6];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_enable <= 1'b0;
            rx_enable <= 1'b0;
            pulse_len <= typea_pkg::pulse_base_128;
            tx_parity_gen <= 1'b1;
            rx_check_enable <= 1'b1;
            anticoll_rx <= 1'b0;
        end else begin
            tx_enable <= stat.tx_enable;
            rx_enable <= stat.rx_enable;
            pulse_len <= stat.pulse_len;
            // card emulation ignores the parity options
            tx_parity_gen <= !(cfg.tx_par_off && reader_mode);
            rx_check_enable <= !(cfg.raw_rx && reader_mode);
            anticoll_rx <= cfg.anticoll;
        end
    end

    // ------------------------------------------------------------
    // transport frame prefix on transmit
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        pre_idle = 3'b001,
        pre_start = 3'b010,
        pre_len = 3'b100
    } prefix_state_t;
    prefix_state_t pstate;
    logic [7:0] len_hold;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pstate <= pre_idle;
            len_hold <= 8'h00;
        end else begin
            case (pstate)
                pre_idle: begin
                    if (tx_frame_start && cfg.transport_frame_enable
                        && tx_enable) begin
                        pstate <= pre_start;
                        len_hold <= tx_frame_len;
                    end
                end
                pre_start: begin
                    if (tx_prefix_ready) begin
                        pstate <= pre_len;
                    end
                end
                pre_len: begin
                    if (tx_prefix_ready) begin
                        pstate <= pre_idle;
                    end
                end
                default: begin
                    pstate <= pre_idle;
                end
            endcase
        end
    end

    assign tx_prefix_valid = pstate != pre_idle;
    always_comb begin
        tx_prefix_byte = (pstate == pre_len) ? len_hold
                                             : typea_pkg::frame_start_byte;
    end

    // ------------------------------------------------------------
    // receive path into fifo
    // ------------------------------------------------------------
    logic first_byte;
    logic drop_byte;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [fifo_width-1:0] fifo_in_data;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [fifo_width-1:0] fifo_out_data;
    logic rx_overflow;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            first_byte <= 1'b0;
        end else if (rx_frame_start) begin
            first_byte <= 1'b1;
        end else if (rx_byte_valid) begin
            first_byte <= 1'b0;
        end
    end

    assign drop_byte = first_byte && cfg.transport_frame_enable
                       && rx_byte == typea_pkg::frame_start_byte;
    assign fifo_in_valid = rx_byte_valid && rx_enable && !drop_byte;
    // parity kept only in raw mode, else zero
    assign fifo_in_data = {rx_parity && !rx_check_enable, rx_byte};
    assign fifo_out_ready = dp_read && dp_addr ==
        typea_pkg::fifo_data_idx * typea_pkg::word_bytes;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_overflow <= 1'b0;
        end else if (fifo_in_valid && !fifo_in_ready) begin
            rx_overflow <= 1'b1; // set wins over clear
        end else if (dp_write && dp_addr ==
                     typea_pkg::status_idx * typea_pkg::word_bytes) begin
            rx_overflow <= 1'b0;
        end
    end

    typea_fifo #(
        .width(fifo_width),
        .depth(fifo_depth)
    ) u_fifo (
        .hclk(hclk),
        .hresetn(hresetn),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // ------------------------------------------------------------
    // read mux, data phase
    // ------------------------------------------------------------
    always_comb begin
        hrdata = 32'h0000_0000;
        if (dp_read) begin
            case (dp_addr)
                typea_pkg::bit_rate_def_idx * typea_pkg::word_bytes: begin
                    hrdata = {24'h000000, bit_rate_def};
                end
                typea_pkg::typea_frame_settings_idx * typea_pkg::word_bytes:
                begin
                    hrdata = {24'h000000, settings};
                end
                typea_pkg::mode_ctrl_idx * typea_pkg::word_bytes: begin
                    hrdata = {24'h000000, mode_ctrl};
                end
                typea_pkg::status_idx * typea_pkg::word_bytes: begin
                    hrdata = {14'h0000, rx_overflow, fifo_out_valid,
                              pulse_len, rx_enable, tx_enable,
                              6'h00, fifo_in_ready, pstate != pre_idle};
                end
                typea_pkg::fifo_data_idx * typea_pkg::word_bytes: begin
                    hrdata = {fifo_out_valid, 22'h000000, fifo_out_data};
                end
                default: begin
                    hrdata = 32'h0000_0000;
                end
            endcase
        end
    end
endmodule : typea_framing_bitrate_config

// ==== dv/typea_cfg_chk.sv ====
`timescale 1ns/100ps
module typea_cfg_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic reader_mode,
    input wire logic tx_frame_start,
    input wire logic [7:0] tx_frame_len,
    input wire logic tx_prefix_valid,
    input wire logic [7:0] tx_prefix_byte,
    input wire logic tx_prefix_ready,
    input wire logic tx_enable,
    input wire logic rx_enable,
    input wire logic [1:0] tx_speed_sel,
    input wire logic tx_parity_gen,
    input wire logic rx_check_enable,
    input wire logic anticoll_rx,
    input wire logic [5:0] pulse_len
);
    logic second;
    logic [7:0] len_q;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ------------------------------------------------------------
    // prefix tracking
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            second <= 1'b0;
            len_q <= 8'h00;
        end else begin
            if (tx_prefix_valid && tx_prefix_ready) second <= ~second;
            if (tx_frame_start && !tx_prefix_valid) len_q <= tx_frame_len;
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_rst;
        disable iff (1'b0) !hresetn |=> tx_parity_gen && rx_check_enable
            && !anticoll_rx && !tx_enable && pulse_len == 6'h23;
    endproperty
    a_rst: assert property (p_rst) else $error("reset value wrong");
    property p_txpar;
        !reader_mode |=> tx_parity_gen;
    endproperty
    a_txpar: assert property (p_txpar) else $error("parity off");
    property p_rxchk;
        !reader_mode |=> rx_check_enable;
    endproperty
    a_rxchk: assert property (p_rxchk) else $error("check off");
    property p_f0;
        tx_prefix_valid && !second |-> tx_prefix_byte == 8'hF0;
    endproperty
    a_f0: assert property (p_f0) else $error("start byte wrong");
    property p_len;
        tx_prefix_valid && second |-> tx_prefix_byte == len_q;
    endproperty
    a_len: assert property (p_len) else $error("length wrong");
    property p_end;
        tx_prefix_valid && tx_prefix_ready && second |=> !tx_prefix_valid;
    endproperty
    a_end: assert property (p_end) else $error("prefix too long");
    property p_both;
        tx_enable == rx_enable;
    endproperty
    a_both: assert property (p_both) else $error("enables differ");
    property p_p128;
        tx_enable && tx_speed_sel == 2'h0 && $stable(tx_speed_sel)
            && $stable(pulse_len) |-> pulse_len inside {[27:42]};
    endproperty
    a_p128: assert property (p_p128) else $error("pulse out");
    property p_pother;
        tx_enable && tx_speed_sel != 2'h0 && $stable(tx_speed_sel)
            && $stable(pulse_len) && $stable(tx_enable) |->
            (tx_speed_sel == 2'h1 && pulse_len inside {[12:24]})
            || (tx_speed_sel == 2'h2 && pulse_len inside {[5:13]})
            || (tx_speed_sel == 2'h3 && pulse_len inside {[2:8]});
    endproperty
    a_pother: assert property (p_pother) else $error("pulse out");
endmodule : typea_cfg_chk
bind typea_framing_bitrate_config typea_cfg_chk u_chk (.hclk, .hresetn,
    .reader_mode, .tx_frame_start, .tx_frame_len, .tx_prefix_valid,
    .tx_prefix_byte, .tx_prefix_ready, .tx_enable, .rx_enable,
    .tx_speed_sel, .tx_parity_gen, .rx_check_enable, .anticoll_rx,
    .pulse_len);

// ==== dv/typea_rf_peer.sv ====
`timescale 1ns/100ps
module typea_rf_peer (
    input wire logic hclk,
    input wire logic slow,
    input wire logic tx_prefix_valid,
    input wire logic [7:0] tx_prefix_byte,
    output logic tx_prefix_ready,
    output logic rx_byte_valid,
    output logic [7:0] rx_byte,
    output logic rx_parity,
    output logic rx_frame_start
);
    logic [7:0] got [4];
    int cnt = 0;
    initial begin
        tx_prefix_ready = 1'b0;
        rx_byte_valid = 1'b0;
        rx_byte = 8'h5A;
        rx_parity = 1'b0;
        rx_frame_start = 1'b0;
    end
    // slow mode stalls every other cycle
    always @(posedge hclk) begin
        if (tx_prefix_valid && tx_prefix_ready) begin
            got[cnt[1:0]] <= tx_prefix_byte;
            cnt <= cnt + 1;
        end
        tx_prefix_ready <= slow ? ~tx_prefix_ready : 1'b1;
    end
    task automatic clr();
        cnt = 0;
    endtask : clr
    // idle lines show the inverse so stale data never looks valid
    task automatic send_byte(input logic first, input logic [7:0] b,
                             input logic p);
        if (first) begin
            rx_frame_start <= 1'b1;
            @(posedge hclk);
            rx_frame_start <= 1'b0;
        end
        rx_byte_valid <= 1'b1;
        rx_byte <= b;
        rx_parity <= p;
        @(posedge hclk);
        rx_byte_valid <= 1'b0;
        rx_byte <= ~b;
        rx_parity <= ~p;
        @(posedge hclk);
    endtask : send_byte
endmodule : typea_rf_peer

// ==== dv/tb_typea_framing_bitrate_config.sv ====
`timescale 1ns/100ps
module tb_typea_framing_bitrate_config;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic reader_mode = 1'b1;
    logic tx_frame_start = 1'b0;
    logic [7:0] tx_frame_len = 8'h00;
    logic slow = 1'b0;
    logic hreadyout, hresp, rx_byte_valid, rx_parity, rx_frame_start;
    logic tx_prefix_valid, tx_prefix_ready, tx_enable, rx_enable;
    logic tx_parity_gen, rx_check_enable, anticoll_rx;
    logic [31:0] hrdata;
    logic [7:0] rx_byte, tx_prefix_byte;
    logic [1:0] tx_speed_sel, rx_speed_sel;
    logic [5:0] pulse_len;
    int err_count = 0;
    int n_checks = 0;
    always #12.5 hclk = ~hclk;
    typea_framing_bitrate_config u_dut (.hclk, .hresetn, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
        .hresp, .hrdata, .reader_mode, .rx_byte_valid, .rx_byte, .rx_parity,
        .rx_frame_start, .tx_frame_start, .tx_frame_len, .tx_prefix_valid,
        .tx_prefix_byte, .tx_prefix_ready, .tx_enable, .rx_enable,
        .tx_speed_sel, .rx_speed_sel, .tx_parity_gen, .rx_check_enable,
        .anticoll_rx, .pulse_len);
    typea_rf_peer u_peer (.hclk, .slow, .tx_prefix_valid, .tx_prefix_byte,
        .tx_prefix_ready, .rx_byte_valid, .rx_byte, .rx_parity,
        .rx_frame_start);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] ad(input logic [7:0] i);
        return {22'h0, i, 2'h0};
    endfunction : ad
    function automatic logic [6:0] exp_pulse(input int r, input int c);
        int lo [4] = '{-8, -6, -4, -3};
        int hi [4] = '{7, 6, 4, 3};
        int base [4] = '{35, 18, 9, 5};
        int s;
        s = (c > 7) ? c - 16 : c;
        return {s >= lo[r] && s <= hi[r], 6'(base[r] + s)};
    endfunction : exp_pulse
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 40);
        q = hrdata;
        if (hreadyout !== 1'b1) begin
            err_count++;
            end_of_test();
        end
    endtask : bus
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [31:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, q);
    endtask : rd
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        logic [31:0] q;
        chk({tx_parity_gen, rx_check_enable, anticoll_rx}, 3'h6);
        rd(ad(typea_pkg::typea_frame_settings_idx), q);
        chk(q, 32'h0);
        rd(ad(typea_pkg::status_idx), q);
        chk(q & 32'h0003FF03, 32'h00008F02);
    endtask : t_reset
    task automatic t_pulse();
        logic [6:0] e;
        logic [31:0] q;
        for (int r = 0; r < 4; r++) begin
            wr(ad(typea_pkg::bit_rate_def_idx), 32'((r << 4) | (3 - r)));
            for (int c = 0; c < 16; c++) begin
                wr(ad(typea_pkg::typea_frame_settings_idx), 32'(c << 1));
                rd(ad(typea_pkg::typea_frame_settings_idx), q);
                e = exp_pulse(r, c);
                chk(q, 32'(c << 1));
                chk(pulse_len, e[5:0]);
                chk({tx_enable, rx_enable}, {2{e[6]}});
                chk({tx_speed_sel, rx_speed_sel}, (r << 2) | (3 - r));
            end
        end
    endtask : t_pulse
    task automatic t_mode();
        logic [31:0] v;
        wr(ad(typea_pkg::bit_rate_def_idx), 32'h0);
        for (int m = 0; m < 2; m++) begin
            reader_mode <= m[0];
            // anticollision only in reader mode, no crc command needed
            v = {24'h0, 7'h60, m[0]};
            wr(ad(typea_pkg::typea_frame_settings_idx), v);
            repeat (2) @(posedge hclk);
            chk({tx_parity_gen, rx_check_enable, anticoll_rx},
                {~m[0], ~m[0], m[0]});
        end
    endtask : t_mode
    task automatic t_rx();
        logic [31:0] q;
        wr(ad(typea_pkg::typea_frame_settings_idx), 32'h60);
        repeat (2) @(posedge hclk);
        u_peer.send_byte(1'b1, 8'hF0, 1'b1);
        u_peer.send_byte(1'b0, 8'h12, 1'b1);
        u_peer.send_byte(1'b0, 8'hF0, 1'b0);
        rd(ad(typea_pkg::fifo_data_idx), q);
        chk(q, 32'h80000112);
        rd(ad(typea_pkg::fifo_data_idx), q);
        chk(q, 32'h800000F0);
        rd(ad(typea_pkg::fifo_data_idx), q);
        chk(q[31], 1'b0);
        wr(ad(typea_pkg::typea_frame_settings_idx), 32'h0);
        repeat (2) @(posedge hclk);
        for (int i = 0; i < 9; i++)
            u_peer.send_byte(i == 0, i == 0 ? 8'hF0 : 8'(i), 1'b1);
        rd(ad(typea_pkg::status_idx), q);
        chk(q & 32'h00030002, 32'h00030000);
        for (int i = 0; i < 8; i++) begin
            rd(ad(typea_pkg::fifo_data_idx), q);
            chk(q, {1'b1, 23'h0, i == 0 ? 8'hF0 : 8'(i)});
        end
        wr(ad(typea_pkg::status_idx), 32'h0);
        rd(ad(typea_pkg::status_idx), q);
        chk(q & 32'h00030002, 32'h00000002);
    endtask : t_rx
    task automatic t_tx();
        int n;
        for (int s = 0; s < 3; s++) begin
            wr(ad(typea_pkg::typea_frame_settings_idx), s < 2 ? 32'h20 : 0);
            repeat (2) @(posedge hclk);
            slow <= s[0];
            u_peer.clr();
            tx_frame_len <= 8'h07;
            tx_frame_start <= 1'b1;
            @(posedge hclk);
            // second start lands while busy and must be dropped
            tx_frame_len <= 8'h17;
            @(posedge hclk);
            tx_frame_start <= 1'b0;
            n = 0;
            while (u_peer.cnt < 2 && n < 30 && s < 2) begin
                @(posedge hclk);
                n++;
            end
            if (n >= 30) begin
                err_count++;
                end_of_test();
            end
            repeat (8) @(posedge hclk);
            chk(u_peer.cnt, s < 2 ? 2 : 0);
            if (s < 2) begin
                chk(u_peer.got[0], typea_pkg::frame_start_byte);
                chk(u_peer.got[1], 8'h07);
            end
        end
    endtask : t_tx
    task automatic t_bus();
        logic [31:0] q;
        wr(32'h00000040, 32'hFFFFFFFF);
        rd(32'h00000040, q);
        chk(q, 32'h0);
        rd(ad(typea_pkg::typea_frame_settings_idx), q);
        chk(q, 32'h0);
        chk(hresp, 1'b0);
    endtask : t_bus
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_pulse();
        t_mode();
        t_rx();
        t_tx();
        t_bus();
        end_of_test();
    end
endmodule : tb_typea_framing_bitrate_config
